// File: logic/eed_consts.svh
/*
 * constants of the external expansion decoder: address bounds, mode masks,
 * wait selections and port 6 pin positions.
 * assumes inclusion by bare name from the design files and the checker.
 */
`ifndef EED_CONSTS_SVH
`define EED_CONSTS_SVH

// ----------------------------------------------------------------------
// address bounds
// ----------------------------------------------------------------------
`define EED_EXT_TOP 17'h0efff
`define EED_ROM_END_32K 17'h08000
`define EED_ROM_END_40K 17'h0a000
`define EED_ROM_END_48K 17'h0c000
`define EED_ROM_END_56K 17'h0e000
`define EED_ROM_END_60K 17'h0f000

// ----------------------------------------------------------------------
// rom size selections
// ----------------------------------------------------------------------
`define EED_ROM_SEL_32K 3'h0
`define EED_ROM_SEL_40K 3'h1
`define EED_ROM_SEL_48K 3'h2
`define EED_ROM_SEL_56K 3'h3
`define EED_ROM_SEL_60K 3'h4

// ----------------------------------------------------------------------
// expansion area spans (last offset from area start)
// ----------------------------------------------------------------------
`define EED_SPAN_256 17'h000ff
`define EED_SPAN_4K 17'h00fff
`define EED_SPAN_16K 17'h03fff

// ----------------------------------------------------------------------
// port 5 upper address masks per mode
// ----------------------------------------------------------------------
`define EED_P5_MASK_NONE 8'h00
`define EED_P5_MASK_4K 8'h0f
`define EED_P5_MASK_16K 8'h3f
`define EED_P5_MASK_FULL 8'hff

// ----------------------------------------------------------------------
// wait control selections
// ----------------------------------------------------------------------
`define EED_WAIT_NONE 2'h0
`define EED_WAIT_ONE 2'h1
`define EED_WAIT_EXT 2'h3

// ----------------------------------------------------------------------
// bit positions within port 6 pins 4 to 7
// ----------------------------------------------------------------------
`define EED_P6_RD 0
`define EED_P6_WR 1
`define EED_P6_WAIT 2
`define EED_P6_ADDRESS_LATCH_STROBE 3

`endif

// File: logic/eed_pkg.sv
/*
 * types of the external expansion decoder: mode codes and bus states.
 * assumes nothing beyond the constants header.
 */
`default_nettype none

package eed_pkg;

    typedef enum logic [2:0]
    {
        EED_MODE_SINGLE0 = 3'b000,
        EED_MODE_SINGLE1 = 3'b001,
        EED_MODE_256 = 3'b011,
        EED_MODE_4K = 3'b100,
        EED_MODE_16K = 3'b101,
        EED_MODE_FULL = 3'b111
    } eed_mode_t;

    typedef enum logic [1:0]
    {
        EED_ST_IDLE = 2'b00,
        EED_ST_ADDR = 2'b01,
        EED_ST_STRB = 2'b10,
        EED_ST_WAIT = 2'b11
    } eed_state_t;

endpackage

`default_nettype wire

// File: logic/eed_dec_if.sv
/*
 * carrier between the bus sequencer and the area decoder.
 * assumes both ends sit in the same clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

interface eed_dec_if;
    logic [15:0] addr;
    logic [2:0] area_sel;
    logic [2:0] rom_sel;
    logic ext_hit;
    logic exp_on;
    logic [7:0] p5_mask;

    modport seq (output addr, output area_sel, output rom_sel,
                 input ext_hit, input exp_on, input p5_mask);
    modport dec (input addr, input area_sel, input rom_sel,
                 output ext_hit, output exp_on, output p5_mask);
endinterface

`default_nettype wire

// File: logic/eed_area_decode.sv
/*
 * area decoder: decides whether an address goes to the external bus and
 * how many port 5 pins carry upper address bits.
 * assumes a stable mode and rom size while an access is decoded.
 */
`timescale 1ns/100ps
`default_nettype none
`include "eed_consts.svh"

module eed_area_decode
    import eed_pkg::*;
(
    // decode carrier
    eed_dec_if.dec d
);

    logic [16:0] rom_end;
    logic [16:0] area_last;
    logic [16:0] addr_w;
    logic mode_ok;

    // ------------------------------------------------------------------
    // first address beyond internal rom
    // ------------------------------------------------------------------
    always_comb
    begin
        case (d.rom_sel)
            `EED_ROM_SEL_32K: rom_end = `EED_ROM_END_32K;
            `EED_ROM_SEL_40K: rom_end = `EED_ROM_END_40K;
            `EED_ROM_SEL_48K: rom_end = `EED_ROM_END_48K;
            `EED_ROM_SEL_56K: rom_end = `EED_ROM_END_56K;
            default: rom_end = `EED_ROM_END_60K;
        endcase
    end

    // ------------------------------------------------------------------
    // area size and address mask per mode
    // ------------------------------------------------------------------
    always_comb
    begin
        mode_ok = 1'b1;
        area_last = `EED_EXT_TOP;
        d.p5_mask = `EED_P5_MASK_NONE;
        case (eed_mode_t'(d.area_sel))
            EED_MODE_256:
            begin
                area_last = rom_end + `EED_SPAN_256;
            end
            EED_MODE_4K:
            begin
                area_last = rom_end + `EED_SPAN_4K;
                d.p5_mask = `EED_P5_MASK_4K;
            end
            EED_MODE_16K:
            begin
                area_last = rom_end + `EED_SPAN_16K;
                d.p5_mask = `EED_P5_MASK_16K;
            end
            // up to the top of external space
            EED_MODE_FULL:
            begin
                area_last = `EED_EXT_TOP;
                d.p5_mask = `EED_P5_MASK_FULL;
            end
            default:
            begin
                mode_ok = 1'b0;
            end
        endcase
        if (area_last > `EED_EXT_TOP)
        begin
            area_last = `EED_EXT_TOP;
        end
    end

    assign addr_w = {1'b0, d.addr};

    // full-size rom leaves no external area
    assign d.exp_on = mode_ok && (rom_end < `EED_ROM_END_60K);

    // outside rom, ram and register space
    // from rom end upward when rom is smaller
    assign d.ext_hit = d.exp_on && (addr_w >= rom_end) && (addr_w <= area_last);

endmodule

`default_nettype wire

// File: logic/eed_top.sv
/*
 * external expansion decoder: runs external bus cycles on the multiplexed
 * bus and hands ports 4 to 6 over between port function and bus function.
 * assumes cpu requests and pin inputs synchronous to sys_clk, and that the
 * cpu holds cpu_req and its address stable while cpu_busy is high.
 */
`timescale 1ns/100ps
`default_nettype none
`include "eed_consts.svh"

module eed_top
    import eed_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // cpu access path
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic cpu_busy,
    output logic cpu_int_sel,
    output logic cpu_ext_ack,
    output logic [7:0] cpu_rdata,
    // configuration
    input wire logic [2:0] expansion_area_select,
    input wire logic [1:0] wait_ctrl,
    input wire logic [2:0] rom_size_sel,
    // port function side
    input wire logic [7:0] port4_port_out,
    input wire logic [7:0] port4_port_oe,
    input wire logic [7:0] port5_port_out,
    input wire logic [7:0] port5_port_oe,
    input wire logic [3:0] port6_port_out,
    input wire logic [3:0] port6_port_oe,
    // pins
    input wire logic [7:0] port4_pins_in,
    output logic [7:0] port4_pins_out,
    output logic [7:0] port4_pins_oe,
    output logic [7:0] port5_pins_out,
    output logic [7:0] port5_pins_oe,
    input wire logic port6_wait_n_in,
    output logic [3:0] port6_hi_out,
    output logic [3:0] port6_hi_oe
);

    eed_state_t state_r;
    eed_state_t state_nxt;
    logic [15:0] addr_r;
    logic [7:0] wdata_r;
    logic we_r;
    logic ack_r;
    logic [7:0] rdata_r;
    logic ext_wait_sel;
    logic cycle_end;
    logic take_ext;
    logic in_strobe;
    logic [7:0] mask;
    logic exp_on;

    eed_dec_if dec_bus ();

    // ------------------------------------------------------------------
    // area decoder
    // ------------------------------------------------------------------
    assign dec_bus.addr = cpu_addr;
    assign dec_bus.area_sel = expansion_area_select;
    assign dec_bus.rom_sel = rom_size_sel;
    assign mask = dec_bus.p5_mask;
    assign exp_on = dec_bus.exp_on;

    eed_area_decode u_dec
    (
        .d(dec_bus)
    );

    // ------------------------------------------------------------------
    // request split between internal and external path
    // ------------------------------------------------------------------
    // no cycle without an external hit
    assign take_ext = (state_r == EED_ST_IDLE) && cpu_req && dec_bus.ext_hit;
    assign cpu_int_sel = (state_r == EED_ST_IDLE) && cpu_req && !dec_bus.ext_hit;
    assign cpu_busy = (state_r != EED_ST_IDLE);
    assign cpu_ext_ack = ack_r;
    assign cpu_rdata = rdata_r;
    assign ext_wait_sel = (wait_ctrl == `EED_WAIT_EXT);
    assign in_strobe = (state_r == EED_ST_STRB) || (state_r == EED_ST_WAIT);

    // ------------------------------------------------------------------
    // bus cycle sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        cycle_end = 1'b0;
        case (state_r)
            EED_ST_IDLE:
            begin
                if (take_ext)
                begin
                    state_nxt = EED_ST_ADDR;
                end
            end
            EED_ST_ADDR:
            begin
                state_nxt = EED_ST_STRB;
            end
            EED_ST_STRB:
            begin
                if ((wait_ctrl == `EED_WAIT_ONE) || ext_wait_sel)
                begin
                    state_nxt = EED_ST_WAIT;
                end
                else
                begin
                    state_nxt = EED_ST_IDLE;
                    cycle_end = 1'b1;
                end
            end
            EED_ST_WAIT:
            begin
                // wait pin sampled only inside a bus cycle
                if (!ext_wait_sel || port6_wait_n_in)
                begin
                    state_nxt = EED_ST_IDLE;
                    cycle_end = 1'b1;
                end
            end
            default:
            begin
                state_nxt = EED_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= EED_ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // address and write data latches
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            addr_r <= 16'h0000;
            wdata_r <= 8'h00;
            we_r <= 1'b0;
        end
        else if ((state_r == EED_ST_IDLE) && cpu_req)
        begin
            addr_r <= cpu_addr;
            wdata_r <= cpu_wdata;
            we_r <= cpu_we && dec_bus.ext_hit;
        end
    end

    // ------------------------------------------------------------------
    // read data capture and completion
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            ack_r <= cycle_end;
            if (cycle_end && !we_r)
            begin
                rdata_r <= port4_pins_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // port 4: multiplexed low address and data
    // ------------------------------------------------------------------
    always_comb
    begin
        port4_pins_out = port4_port_out;
        port4_pins_oe = port4_port_oe;
        // bus takes port 4 while expansion is on
        // low address then data on port 4
        if (exp_on)
        begin
            port4_pins_out = addr_r[7:0];
            port4_pins_oe = 8'h00;
            if (state_r == EED_ST_ADDR)
            begin
                port4_pins_oe = 8'hff;
            end
            else if (in_strobe && we_r)
            begin
                port4_pins_out = wdata_r;
                port4_pins_oe = 8'hff;
            end
        end
    end

    // ------------------------------------------------------------------
    // port 5: upper address bits per mode
    // ------------------------------------------------------------------
    // mask selects address pins of port 5
    assign port5_pins_out = (addr_r[15:8] & mask) | (port5_port_out & ~mask);
    assign port5_pins_oe = mask | (port5_port_oe & ~mask);

    // ------------------------------------------------------------------
    // port 6: strobes, wait and address strobe
    // ------------------------------------------------------------------
    always_comb
    begin
        port6_hi_out = port6_port_out;
        port6_hi_oe = port6_port_oe;
        if (exp_on)
        begin
            // strobes low only in an external cycle
            port6_hi_out[`EED_P6_RD] = !(in_strobe && !we_r);
            port6_hi_out[`EED_P6_WR] = !(in_strobe && we_r);
            port6_hi_out[`EED_P6_ADDRESS_LATCH_STROBE] = (state_r == EED_ST_ADDR);
            port6_hi_oe[`EED_P6_RD] = 1'b1;
            port6_hi_oe[`EED_P6_WR] = 1'b1;
            port6_hi_oe[`EED_P6_ADDRESS_LATCH_STROBE] = 1'b1;
            // wait pin stays port without external wait
            if (ext_wait_sel)
            begin
                port6_hi_out[`EED_P6_WAIT] = 1'b0;
                port6_hi_oe[`EED_P6_WAIT] = 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// File: verification/eed_mem_model.sv
/*
 * external memory on the muxed bus, stretching each strobe by a wait count.
 * assumes the decoder's strobe pins and the resolved port 4 wire level.
 */
`timescale 1ns/100ps
`default_nettype none

module eed_mem_model
(
    // bus from the decoder
    input wire logic sys_clk,
    input wire logic [3:0] ctl,
    input wire logic [7:0] ad_out,
    input wire logic [7:0] hi,
    input wire logic [2:0] stall,
    // answers to the decoder
    output logic [7:0] ad_in,
    output logic wait_n
);
    logic [7:0] mem [0:65535];
    logic [7:0] lo_r;
    logic [7:0] last_r = 8'h5a;
    logic [2:0] cnt_r = 3'h0;
    logic strb;

    assign strb = !ctl[0] || !ctl[1];
    // released bus shows the inverse of the last value
    assign ad_in = !ctl[0] ? mem[{hi, lo_r}] : ~last_r;
    assign wait_n = !(strb && cnt_r < stall);

    always @(posedge sys_clk)
    begin
        if (ctl[3])
            lo_r <= ad_out;
        if (!ctl[1])
            mem[{hi, lo_r}] <= ad_out;
        if (!ctl[0])
            last_r <= ad_in;
        cnt_r <= strb ? cnt_r + 3'h1 : 3'h0;
    end
endmodule

`default_nettype wire

// File: verification/eed_top_asserts.sv
/*
 * assertions on the decoder's pins and cpu handshake.
 * assumes binding to eed_top in a single clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
`include "eed_consts.svh"

module eed_top_asserts
(
    // clock, reset and cpu path
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cpu_req,
    input wire logic cpu_busy,
    input wire logic cpu_int_sel,
    input wire logic cpu_ext_ack,
    // configuration and port side
    input wire logic [2:0] expansion_area_select,
    input wire logic [1:0] wait_ctrl,
    input wire logic [2:0] rom_size_sel,
    input wire logic [7:0] port4_port_out,
    input wire logic [7:0] port4_port_oe,
    input wire logic [7:0] port5_port_oe,
    input wire logic [3:0] port6_port_out,
    input wire logic [3:0] port6_port_oe,
    // pins
    input wire logic [7:0] port4_pins_out,
    input wire logic [7:0] port4_pins_oe,
    input wire logic [7:0] port5_pins_oe,
    input wire logic port6_wait_n_in,
    input wire logic [3:0] port6_hi_out,
    input wire logic [3:0] port6_hi_oe
);
    logic en_x;
    logic [7:0] msk;

    always_comb
    begin
        en_x = rom_size_sel < 3'h4;
        msk = `EED_P5_MASK_NONE;
        case (expansion_area_select)
            3'b011: msk = `EED_P5_MASK_NONE;
            3'b100: msk = `EED_P5_MASK_4K;
            3'b101: msk = `EED_P5_MASK_16K;
            3'b111: msk = `EED_P5_MASK_FULL;
            default: en_x = 1'b0;
        endcase
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_strb_idle;
        en_x && !cpu_busy |-> port6_hi_out[1:0] == 2'b11 && !port6_hi_out[3];
    endproperty
    property p_single;
        !en_x |-> !cpu_busy && port4_pins_out == port4_port_out
            && port4_pins_oe == port4_port_oe && port6_hi_oe == port6_port_oe;
    endproperty
    property p_int;
        cpu_req && !cpu_busy && cpu_int_sel |=> !cpu_busy;
    endproperty
    property p_take;
        en_x && cpu_req && !cpu_busy && !cpu_int_sel |=> cpu_busy;
    endproperty
    property p_pins;
        $rose(cpu_busy) |-> port6_hi_out[3] && port4_pins_oe == 8'hff;
    endproperty
    property p_ack0;
        $rose(cpu_busy) && wait_ctrl != 2'h1 && wait_ctrl != 2'h3 |-> ##2 cpu_ext_ack;
    endproperty
    property p_wait_port;
        wait_ctrl != 2'h3 |-> port6_hi_out[2] == port6_port_out[2]
            && port6_hi_oe[2] == port6_port_oe[2];
    endproperty
    property p_mask;
        en_x |-> (port5_pins_oe & msk) == msk
            && (port5_pins_oe & ~msk) == (port5_port_oe & ~msk);
    endproperty
    property p_stretch;
        cpu_busy && wait_ctrl == 2'h3 && !port6_wait_n_in |=> !cpu_ext_ack;
    endproperty

    a_strb_idle: assert property (p_strb_idle) else $error("strobe active while idle");
    a_single: assert property (p_single) else $error("single chip pins not port");
    a_int: assert property (p_int) else $error("internal access started a cycle");
    a_take: assert property (p_take) else $error("external access not taken");
    a_pins: assert property (p_pins) else $error("bus pins not taken over");
    a_ack0: assert property (p_ack0) else $error("ack late without wait");
    a_wait_port: assert property (p_wait_port) else $error("wait pin not port");
    a_mask: assert property (p_mask) else $error("port 5 mask wrong");
    a_stretch: assert property (p_stretch) else $error("ack during wait");

    c_ext: cover property ($rose(cpu_ext_ack));
    c_int: cover property (cpu_req && cpu_int_sel);
    c_wait: cover property (cpu_busy && !port6_wait_n_in);
endmodule

bind eed_top eed_top_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .cpu_req(cpu_req),
    .cpu_busy(cpu_busy), .cpu_int_sel(cpu_int_sel), .cpu_ext_ack(cpu_ext_ack),
    .expansion_area_select(expansion_area_select), .wait_ctrl(wait_ctrl),
    .rom_size_sel(rom_size_sel), .port4_port_out(port4_port_out),
    .port4_port_oe(port4_port_oe), .port5_port_oe(port5_port_oe),
    .port6_port_out(port6_port_out), .port6_port_oe(port6_port_oe),
    .port4_pins_out(port4_pins_out), .port4_pins_oe(port4_pins_oe),
    .port5_pins_oe(port5_pins_oe), .port6_wait_n_in(port6_wait_n_in),
    .port6_hi_out(port6_hi_out), .port6_hi_oe(port6_hi_oe));

`default_nettype wire

// File: verification/eed_top_tb.sv
/*
 * testbench of the expansion decoder against an external memory model.
 * assumes the checker is bound to eed_top.
 */
`timescale 1ns/100ps
`default_nettype none

module eed_top_tb;
    // {area code, rom size and external flag, address}
    localparam logic [23:0] ROWS [19] = '{24'h3180ff, 24'h308100, 24'h307fff,
        24'h418fff, 24'h409000, 24'h51bfff, 24'h50c000, 24'h71efff, 24'h70f000,
        24'h70ff10, 24'h78efff, 24'h77e000, 24'h76dfff, 24'h33a0ff, 24'h32a100,
        24'h45cfff, 24'h008000, 24'h108000, 24'h208000};
    localparam logic [1:0] WCS [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    localparam int LAT [4] = '{3, 4, 6, 3};

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cpu_req = 1'b0;
    logic cpu_we = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [15:0] seen_a;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] pv = 8'h3c;
    logic [2:0] area = 3'h0;
    logic [2:0] rom = 3'h0;
    logic [2:0] stall = 3'h3;
    logic [1:0] wc = 2'h0;
    logic cpu_busy, cpu_int_sel, cpu_ext_ack, wait_n;
    logic [7:0] cpu_rdata, p4_in, p4_w, p4_out, p4_oe, p5_out, p5_oe;
    logic [3:0] p6_out, p6_oe;
    logic [7:0] p5_msk, p5_want;
    int error_cnt = 0;
    int num_checks = 0;
    int n;

    // wire level of port 4 from both drivers
    assign p4_w = (p4_oe & p4_out) | (~p4_oe & p4_in);

    eed_top dut (.sys_clk(sys_clk), .rst(rst), .cpu_req(cpu_req), .cpu_we(cpu_we),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_busy(cpu_busy),
        .cpu_int_sel(cpu_int_sel), .cpu_ext_ack(cpu_ext_ack), .cpu_rdata(cpu_rdata),
        .expansion_area_select(area), .wait_ctrl(wc), .rom_size_sel(rom),
        .port4_port_out(pv), .port4_port_oe(~pv), .port5_port_out(pv),
        .port5_port_oe(pv), .port6_port_out(pv[3:0]), .port6_port_oe(pv[7:4]),
        .port4_pins_in(p4_w), .port4_pins_out(p4_out), .port4_pins_oe(p4_oe),
        .port5_pins_out(p5_out), .port5_pins_oe(p5_oe), .port6_wait_n_in(wait_n),
        .port6_hi_out(p6_out), .port6_hi_oe(p6_oe));

    eed_mem_model mem (.sys_clk(sys_clk), .ctl(p6_out), .ad_out(p4_w), .hi(p5_out),
        .stall(stall), .ad_in(p4_in), .wait_n(wait_n));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task chk(input string what, input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task acc(input logic we, input logic [15:0] a, input logic [7:0] d, output int cyc);
        @(posedge sys_clk);
        #1;
        cpu_we = we;
        cpu_addr = a;
        cpu_wdata = d;
        cpu_req = 1'b1;
        cyc = 0;
        while (cpu_ext_ack !== 1'b1 && cyc < 20)
        begin
            @(posedge sys_clk);
            #1;
            cyc++;
            if (cyc == 1)
                seen_a = {p5_out, p4_out};
        end
        cpu_req = 1'b0;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_single;
        area = 3'h0;
        wc = 2'h3;
        pv = 8'h96;
        cpu_addr = 16'h8000;
        cpu_req = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("busy", {15'h0000, cpu_busy}, 16'h0000);
        chk("port4", {p4_out, p4_oe}, {pv, ~pv});
        chk("port6", {8'h00, p6_out, p6_oe}, {8'h00, pv[3:0], pv[7:4]});
        cpu_req = 1'b0;
        $display("single chip test done");
    endtask

    task t_area;
        wc = 2'h0;
        foreach (ROWS[i])
        begin
            @(posedge sys_clk);
            #1;
            area = ROWS[i][22:20];
            rom = ROWS[i][19:17];
            cpu_we = 1'b0;
            cpu_addr = ROWS[i][15:0];
            cpu_req = 1'b1;
            #1;
            chk("int_sel", 16'(cpu_int_sel), 16'(!ROWS[i][16]));
            @(posedge sys_clk);
            #1;
            chk("busy", 16'(cpu_busy), 16'(ROWS[i][16]));
            // upper address pins in the address cycle
            if (ROWS[i][16])
            begin
                p5_msk = (area == 3'h4) ? 8'h0f : (area == 3'h5) ? 8'h3f : {8{area == 3'h7}};
                p5_want = (ROWS[i][15:8] & p5_msk) | (pv & ~p5_msk);
                chk("port5 pins", 16'(p5_out), 16'(p5_want));
            end
            n = 0;
            while (cpu_busy === 1'b1 && n < 20)
            begin
                @(posedge sys_clk);
                #1;
                n++;
            end
            chk("cycle end", 16'(cpu_busy), 16'h0000);
            cpu_req = 1'b0;
        end
        $display("area test done");
    endtask

    task t_rw;
        area = 3'h7;
        rom = 3'h0;
        foreach (WCS[i])
        begin
            wc = WCS[i];
            acc(1'b1, 16'(16'h8123 + i), 8'(8'ha5 ^ i), n);
            chk("write cycles", 16'(n), 16'(LAT[i]));
            chk("address pins", seen_a, 16'(16'h8123 + i));
            acc(1'b0, 16'(16'h8123 + i), 8'h00, n);
            chk("read cycles", 16'(n), 16'(LAT[i]));
            chk("read data", {8'h00, cpu_rdata}, 16'(8'ha5 ^ i));
        end
        $display("read write test done");
    endtask

    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_single;
        t_area;
        t_rw;
        conclude;
    end

    initial
    begin
        #20000;
        error_cnt++;
        conclude;
    end
endmodule

`default_nettype wire
